// file: rtl/pmc_pkg.sv
package pmc_pkg;

  // management register addresses and page selection
  localparam logic [4:0] REG_MODE_CTRL = 5'h00;
  localparam logic [4:0] REG_PAGE_SEL = 5'h1F;
  localparam logic [15:0] PAGE_MAIN = 16'h0000;

  // mode control field positions
  localparam int B_SRST = 15;
  localparam int B_LOOP = 14;
  localparam int B_SPD_LO = 13;
  localparam int B_ANEG = 12;
  localparam int B_PWRDN = 11;
  localparam int B_ISO = 10;
  localparam int B_RESTART = 9;
  localparam int B_DUPLEX = 8;
  localparam int B_COLTEST = 7;
  localparam int B_SPD_HI = 6;
  localparam int B_UNI = 5;

  localparam logic [15:0] CTRL_DEF = 16'h1040;
  localparam logic [15:0] CTRL_WMASK = 16'hFFE0;
  localparam logic [15:0] CTRL_SRST_BIT = 16'h8000;

  // forced speed codes, high bit first
  localparam logic [1:0] SPD_10 = 2'h0;
  localparam logic [1:0] SPD_100 = 2'h1;
  localparam logic [1:0] SPD_1000 = 2'h2;
  localparam logic [1:0] SPD_RSVD = 2'h3;

  // media mode codes
  localparam logic [2:0] MED_COPPER = 3'h0;
  localparam logic [2:0] MED_PROTO = 3'h1;
  localparam logic [2:0] MED_1000X = 3'h2;
  localparam logic [2:0] MED_100FX = 3'h3;

  // software reset quiet time
  localparam int CLK_PERIOD_NS = 50;
  localparam int SRST_WAIT_NS = 1000;
  localparam int SRST_CYC = (SRST_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [4:0] SRST_CNT_INIT = 5'(SRST_CYC);

  // management frame fields
  localparam logic [1:0] OP_WR = 2'h1;
  localparam logic [1:0] OP_RD = 2'h2;
  localparam logic [3:0] HDR_LAST = 4'hB;
  localparam logic [3:0] DATA_LAST = 4'hF;

  typedef enum logic [2:0] {PMC_IDLE, PMC_ST, PMC_HDR, PMC_TA, PMC_DATA} pmc_mdio_st_e;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [4:0] addr;
    logic [15:0] data;
  } pmc_req_s;

  typedef struct packed {
    logic en;
    logic [7:0] data;
  } pmc_byte_s;

endpackage : pmc_pkg

// file: rtl/pmc_mdio_frame.sv
`timescale 1ns/1ps
module pmc_mdio_frame
  import pmc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic mdc,
  input wire logic mdio_i,
  input wire logic [4:0] phy_addr,
  input wire logic [15:0] rd_data,
  output logic mdio_o,
  output logic mdio_oe,
  output pmc_req_s req
);

  typedef struct packed {
    logic mdc_q;
    pmc_mdio_st_e fsm;
    logic [3:0] cnt;
    logic ones;
    logic rd;
    logic [15:0] sh;
    logic o;
    logic oe;
    pmc_req_s req;
  } pmc_frm_s;

  pmc_frm_s st;
  pmc_frm_s next_st;

  assign mdio_o = st.o;
  assign mdio_oe = st.oe;
  assign req = st.req;

  always_comb begin
    logic [11:0] hdr;
    hdr = {st.sh[10:0], mdio_i};
    next_st = st;
    next_st.mdc_q = mdc;
    next_st.req.wr = 1'b0;
    next_st.req.rd = 1'b0;
    // serial bits are taken on the sampled rising edge of the management clock
    if (mdc && !st.mdc_q) begin
      case (st.fsm)
        PMC_IDLE: begin
          if (mdio_i) begin
            next_st.ones = 1'b1;
          end else if (st.ones) begin
            next_st.fsm = PMC_ST;
          end
        end
        PMC_ST: begin
          next_st.ones = 1'b0;
          next_st.cnt = 4'h0;
          next_st.fsm = mdio_i ? PMC_HDR : PMC_IDLE;
        end
        PMC_HDR: begin
          next_st.sh = {st.sh[14:0], mdio_i};
          next_st.cnt = st.cnt + 4'h1;
          if (st.cnt == HDR_LAST) begin
            next_st.cnt = 4'h0;
            next_st.rd = (hdr[11:10] == OP_RD);
            next_st.req.addr = hdr[4:0];
            if (hdr[9:5] != phy_addr || (hdr[11:10] != OP_RD && hdr[11:10] != OP_WR)) begin
              next_st.fsm = PMC_IDLE;
            end else begin
              next_st.fsm = PMC_TA;
              next_st.req.rd = (hdr[11:10] == OP_RD);
            end
          end
        end
        PMC_TA: begin
          if (st.cnt == 4'h0) begin
            next_st.cnt = 4'h1;
            next_st.oe = st.rd;
            next_st.o = 1'b0;
          end else begin
            next_st.cnt = 4'h0;
            next_st.fsm = PMC_DATA;
            if (st.rd) begin
              next_st.sh = rd_data;
              next_st.o = rd_data[15];
            end
          end
        end
        PMC_DATA: begin
          next_st.cnt = st.cnt + 4'h1;
          if (st.rd) begin
            next_st.o = st.sh[14];
            next_st.sh = {st.sh[14:0], 1'b0};
          end else begin
            next_st.sh = {st.sh[14:0], mdio_i};
          end
          if (st.cnt == DATA_LAST) begin
            next_st.fsm = PMC_IDLE;
            next_st.oe = 1'b0;
            next_st.o = 1'b0;
            next_st.req.wr = !st.rd;
            next_st.req.data = {st.sh[14:0], mdio_i};
          end
        end
        default: begin
          next_st.fsm = PMC_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

endmodule : pmc_mdio_frame

// file: rtl/pmc_mode_ctrl.sv
`timescale 1ns/1ps
// Behaviour
// - a one written to bit 15 returns all management registers to default and then clears.
// - bit 14 loops MAC transmit data back to MAC receive at the programmed speed and duplex.
// - forced speed is bit 6 high and bit 13 low, 00/01/10 for 10/100/1000, 11 reserved.
// - bit 10 disables all MAC-side outputs and ignores all MAC-side inputs.
// - a one written to bit 9 restarts autonegotiation and then clears.
// - bit 7 turns the collision test on and off.
// - bit 5 is ignored unless autonegotiation is off and full duplex is selected.
// - effective bit 5 lets transmit run without link, otherwise transmit needs link.
// - unidirectional transmit applies only in the 100BASE-FX and 1000BASE-X media modes.
// - half duplex is not available while MACsec runs or legacy-MAC EEE is on.
module pmc_mode_ctrl
  import pmc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic mdc,
  input wire logic mdio_i,
  output logic mdio_o,
  output logic mdio_oe,
  input wire logic [4:0] phy_addr,
  input wire logic [2:0] media_mode,
  input wire logic link_up,
  input wire logic macsec_active,
  input wire logic eee_legacy_en,
  input wire pmc_byte_s mac_tx,
  output pmc_byte_s mac_rx,
  output logic mac_col,
  output logic mac_oe,
  input wire pmc_byte_s med_rx,
  output pmc_byte_s med_tx,
  output logic loopback_en,
  output logic [1:0] speed_sel,
  output logic aneg_en,
  output logic aneg_restart,
  output logic power_down,
  output logic isolate_en,
  output logic duplex_full,
  output logic col_test_en,
  output logic uni_tx_en,
  output logic soft_reset
);

  typedef struct packed {
    logic [15:0] ctrl;
    logic [15:0] page;
    logic [4:0] srst_cnt;
    logic [15:0] rd_data;
    logic [1:0] speed;
    logic duplex;
    logic uni;
    logic restart;
    pmc_byte_s mac_rx;
    logic mac_col;
    logic mac_oe;
    pmc_byte_s med_tx;
  } pmc_top_s;

  pmc_top_s st;
  pmc_top_s next_st;
  pmc_req_s req;

  pmc_mdio_frame u_frame (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .mdc(mdc),
    .mdio_i(mdio_i),
    .phy_addr(phy_addr),
    .rd_data(st.rd_data),
    .mdio_o(mdio_o),
    .mdio_oe(mdio_oe),
    .req(req)
  );

  assign loopback_en = st.ctrl[B_LOOP];
  assign aneg_en = st.ctrl[B_ANEG];
  assign power_down = st.ctrl[B_PWRDN];
  assign isolate_en = st.ctrl[B_ISO];
  assign col_test_en = st.ctrl[B_COLTEST];
  assign soft_reset = st.ctrl[B_SRST];
  assign aneg_restart = st.restart;
  assign speed_sel = st.speed;
  assign duplex_full = st.duplex;
  assign uni_tx_en = st.uni;
  assign mac_rx = st.mac_rx;
  assign mac_col = st.mac_col;
  assign mac_oe = st.mac_oe;
  assign med_tx = st.med_tx;

  always_comb begin
    logic busy;
    logic fiber;
    logic uni_active;
    logic tx_ok;
    logic [1:0] code;
    pmc_byte_s mac_in;
    pmc_byte_s rx_src;
    busy = st.ctrl[B_SRST];
    fiber = (media_mode == MED_1000X) || (media_mode == MED_100FX);
    code = {st.ctrl[B_SPD_HI], st.ctrl[B_SPD_LO]};
    mac_in = st.ctrl[B_ISO] ? '0 : mac_tx;
    uni_active = 1'b0;
    tx_ok = 1'b0;
    rx_src = '0;
    next_st = st;

    // restart request lives for one cycle and leaves a one-cycle pulse
    next_st.restart = st.ctrl[B_RESTART];
    next_st.ctrl[B_RESTART] = 1'b0;

    // reset bit reads back set until the quiet time is over
    if (st.srst_cnt != 5'h00) begin
      next_st.srst_cnt = st.srst_cnt - 5'h01;
    end else begin
      next_st.ctrl[B_SRST] = 1'b0;
    end

    // writes during the quiet time are dropped rather than half applied
    if (req.wr && !busy) begin
      if (req.addr == REG_MODE_CTRL && st.page == PAGE_MAIN) begin
        if (req.data[B_SRST]) begin
          next_st.ctrl = CTRL_DEF | CTRL_SRST_BIT;
          next_st.page = PAGE_MAIN;
          next_st.srst_cnt = SRST_CNT_INIT;
          next_st.restart = 1'b0;
        end else begin
          next_st.ctrl = req.data & CTRL_WMASK;
        end
      end else if (req.addr == REG_PAGE_SEL) begin
        next_st.page = req.data;
      end
    end

    if (req.rd) begin
      if (req.addr == REG_MODE_CTRL && st.page == PAGE_MAIN) begin
        next_st.rd_data = st.ctrl;
      end else if (req.addr == REG_PAGE_SEL) begin
        next_st.rd_data = st.page;
      end else begin
        next_st.rd_data = 16'h0000;
      end
    end

    // reserved speed code keeps the last valid speed running
    next_st.speed = (code != SPD_RSVD) ? code : st.speed;
    next_st.duplex = st.ctrl[B_DUPLEX] | macsec_active | eee_legacy_en;

    uni_active = st.ctrl[B_UNI] & ~st.ctrl[B_ANEG] & st.ctrl[B_DUPLEX] & fiber;
    next_st.uni = uni_active;
    tx_ok = link_up | uni_active;

    if (tx_ok && !st.ctrl[B_LOOP] && !st.ctrl[B_PWRDN]) begin
      next_st.med_tx = mac_in;
    end else begin
      next_st.med_tx = '0;
    end

    rx_src = st.ctrl[B_LOOP] ? mac_in : med_rx;
    next_st.mac_rx = (st.ctrl[B_ISO] || st.ctrl[B_PWRDN]) ? '0 : rx_src;
    next_st.mac_col = st.ctrl[B_COLTEST] & mac_in.en & ~st.ctrl[B_PWRDN];
    next_st.mac_oe = ~st.ctrl[B_ISO];
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
      st.ctrl <= CTRL_DEF;
      st.page <= PAGE_MAIN;
      st.speed <= SPD_1000;
      st.mac_oe <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  property p_srst_defaults;
    @(posedge ref_clk) disable iff (!rst_n)
      $rose(st.ctrl[B_SRST]) |-> (st.ctrl[14:0] == CTRL_DEF[14:0]) && (st.page == PAGE_MAIN);
  endproperty
  a_srst_defaults: assert property (p_srst_defaults)
    else $error("software reset did not restore defaults");

  property p_srst_clears;
    @(posedge ref_clk) disable iff (!rst_n)
      $rose(st.ctrl[B_SRST]) |-> st.ctrl[B_SRST] [*8] ##[1:20] !st.ctrl[B_SRST];
  endproperty
  a_srst_clears: assert property (p_srst_clears)
    else $error("software reset bit did not hold then clear");

  property p_loopback;
    @(posedge ref_clk) disable iff (!rst_n)
      (st.ctrl[B_LOOP] && !st.ctrl[B_ISO] && !st.ctrl[B_PWRDN])
        |=> (mac_rx == $past(mac_tx)) && !med_tx.en;
  endproperty
  a_loopback: assert property (p_loopback)
    else $error("loopback data mismatch");

  property p_speed;
    @(posedge ref_clk) disable iff (!rst_n)
      ({st.ctrl[B_SPD_HI], st.ctrl[B_SPD_LO]} != SPD_RSVD)
        |=> speed_sel == $past({st.ctrl[B_SPD_HI], st.ctrl[B_SPD_LO]});
  endproperty
  a_speed: assert property (p_speed)
    else $error("speed output does not follow the speed field");

  property p_isolate;
    @(posedge ref_clk) disable iff (!rst_n)
      st.ctrl[B_ISO] |=> !mac_oe && !mac_rx.en && !mac_col && !med_tx.en;
  endproperty
  a_isolate: assert property (p_isolate)
    else $error("MAC side active while isolated");

  property p_restart;
    @(posedge ref_clk) disable iff (!rst_n)
      $rose(st.ctrl[B_RESTART]) |=> aneg_restart && !st.ctrl[B_RESTART] ##1 !aneg_restart;
  endproperty
  a_restart: assert property (p_restart)
    else $error("restart bit did not pulse and clear");

  property p_coltest;
    @(posedge ref_clk) disable iff (!rst_n)
      (!st.ctrl[B_COLTEST] |=> !mac_col)
        and ((st.ctrl[B_COLTEST] && mac_tx.en && !st.ctrl[B_ISO] && !st.ctrl[B_PWRDN])
          |=> mac_col);
  endproperty
  a_coltest: assert property (p_coltest)
    else $error("collision test output wrong");

  property p_uni_ignored;
    @(posedge ref_clk) disable iff (!rst_n)
      ((st.ctrl[B_ANEG] || !st.ctrl[B_DUPLEX]) && !link_up) |=> !med_tx.en && !uni_tx_en;
  endproperty
  a_uni_ignored: assert property (p_uni_ignored)
    else $error("unidirectional mode acted while it should be ignored");

  // judged on the live field, since uni_tx_en lags a write by one cycle
  property p_uni_tx;
    @(posedge ref_clk) disable iff (!rst_n)
      (st.ctrl[B_UNI] && !st.ctrl[B_ANEG] && st.ctrl[B_DUPLEX]
        && (media_mode == MED_1000X || media_mode == MED_100FX)
        && mac_tx.en && !st.ctrl[B_ISO] && !st.ctrl[B_LOOP] && !st.ctrl[B_PWRDN])
        |=> med_tx.en && uni_tx_en;
  endproperty
  a_uni_tx: assert property (p_uni_tx)
    else $error("unidirectional transmit blocked");

  property p_uni_media;
    @(posedge ref_clk) disable iff (!rst_n)
      (media_mode != MED_1000X && media_mode != MED_100FX && !link_up) |=> !med_tx.en;
  endproperty
  a_uni_media: assert property (p_uni_media)
    else $error("transmit without link outside fiber modes");

  property p_no_half;
    @(posedge ref_clk) disable iff (!rst_n)
      (macsec_active || eee_legacy_en) |=> duplex_full;
  endproperty
  a_no_half: assert property (p_no_half)
    else $error("half duplex active while not supported");

  property p_reserved_zero;
    @(posedge ref_clk) disable iff (!rst_n)
      (st.ctrl[4:0] == 5'h00) && (speed_sel != SPD_RSVD);
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("reserved bits or speed code nonzero");

endmodule : pmc_mode_ctrl

// file: testbench/pmc_sta.sv
`timescale 1ns/1ps
module pmc_sta
  import pmc_pkg::*;
#(
  parameter logic [4:0] PHYAD = 5'h01
)
(
  input wire logic ref_clk,
  input wire logic mdio,
  output logic mdc,
  output logic sta_o,
  output logic sta_oe
);
  initial begin
    mdc = 1'b0;
    sta_o = 1'b1;
    sta_oe = 1'b0;
  end

  // two ref_clk low then two high; line read just before the rise
  task automatic bit_io(input logic v, input logic drv, output logic smp);
    @(posedge ref_clk);
    mdc <= 1'b0;
    sta_o <= v;
    sta_oe <= drv;
    repeat (2) @(posedge ref_clk);
    smp = mdio;
    mdc <= 1'b1;
    @(posedge ref_clk);
  endtask : bit_io

  task automatic frame(input logic [1:0] op, input logic [4:0] ra, input logic [15:0] wd,
      output logic [15:0] rdv);
    logic [14:0] hdr;
    logic wr;
    logic s;
    hdr = {1'b1, 2'b01, op, PHYAD, ra};
    wr = (op == OP_WR);
    for (int i = 14; i >= 0; i--) bit_io(hdr[i], 1'b1, s);
    // on a read the line is let go for the turnaround
    bit_io(1'b1, wr, s);
    bit_io(1'b0, wr, s);
    for (int i = 15; i >= 0; i--) begin
      bit_io(wd[i], wr, s);
      rdv[i] = s;
    end
    @(posedge ref_clk);
    mdc <= 1'b0;
    sta_oe <= 1'b0;
    repeat (4) @(posedge ref_clk);
  endtask : frame

  task automatic wr(input logic [4:0] ra, input logic [15:0] d);
    logic [15:0] junk;
    frame(OP_WR, ra, d, junk);
    // a write frame inside the quiet time would be dropped
    if (ra == REG_MODE_CTRL && d[B_SRST]) repeat (SRST_CYC + 2) @(posedge ref_clk);
  endtask : wr

  task automatic rd(input logic [4:0] ra, output logic [15:0] d);
    frame(OP_RD, ra, 16'h0000, d);
  endtask : rd

  task automatic force_1000();
    wr(5'h09, 16'h0800);
    wr(REG_MODE_CTRL, 16'h0140);
  endtask : force_1000
endmodule : pmc_sta

// file: testbench/testbench.sv
`timescale 1ns/1ps
module testbench
  import pmc_pkg::*;
;
  logic ref_clk, rst_n, mdc, mdio_w, sta_o, sta_oe, mdio_o, mdio_oe;
  logic link_up, macsec_active, eee_legacy_en, mac_col, mac_oe, loopback_en, aneg_en;
  logic aneg_restart, power_down, isolate_en, duplex_full, col_test_en, uni_tx_en, soft_reset;
  logic [2:0] media_mode;
  logic [1:0] speed_sel;
  logic [15:0] rv, d;
  pmc_byte_s mac_tx, mac_rx, med_rx, med_tx;
  int n_mismatch, checked, cyc, n_pulse, n_srst, p0;

  // pull-up holds the line high when nobody drives it
  assign mdio_w = mdio_oe ? mdio_o : (sta_oe ? sta_o : 1'b1);

  pmc_mode_ctrl dut (.ref_clk, .rst_n, .mdc, .mdio_i(mdio_w), .mdio_o, .mdio_oe,
    .phy_addr(5'h01), .media_mode, .link_up, .macsec_active, .eee_legacy_en, .mac_tx,
    .mac_rx, .mac_col, .mac_oe, .med_rx, .med_tx, .loopback_en, .speed_sel, .aneg_en,
    .aneg_restart, .power_down, .isolate_en, .duplex_full, .col_test_en, .uni_tx_en,
    .soft_reset);
  pmc_sta sta (.ref_clk, .mdio(mdio_w), .mdc, .sta_o, .sta_oe);

  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (aneg_restart === 1'b1) n_pulse <= n_pulse + 1;
    if (soft_reset === 1'b1) n_srst <= n_srst + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      conclude();
    end
  end

  task chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task chk1(input logic got, input logic exp);
    chk({15'h0, got}, {15'h0, exp});
  endtask : chk1

  task conclude();
    $display("mismatches %0d checks %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : conclude

  task w(input logic [15:0] v);
    sta.wr(REG_MODE_CTRL, v);
    #1;
  endtask : w

  task side(input logic lu, input logic ms, input logic ee, input logic [2:0] mm);
    @(posedge ref_clk);
    link_up <= lu;
    macsec_active <= ms;
    eee_legacy_en <= ee;
    media_mode <= mm;
  endtask : side

  task drv(input pmc_byte_s tx, input pmc_byte_s rx);
    @(posedge ref_clk);
    mac_tx <= tx;
    med_rx <= rx;
    repeat (2) @(posedge ref_clk);
    #1;
  endtask : drv

  initial begin
    rst_n = 1'b0;
    link_up = 1'b0;
    macsec_active = 1'b0;
    eee_legacy_en = 1'b0;
    media_mode = MED_COPPER;
    mac_tx = '0;
    med_rx = '0;
    repeat (20) @(posedge ref_clk);
    #1;
    chk({2'h0, speed_sel, aneg_en, mac_oe, mdio_oe, loopback_en, power_down, isolate_en,
      duplex_full, col_test_en, uni_tx_en, soft_reset, aneg_restart, mac_col}, 16'h2C00);
    @(posedge ref_clk) rst_n <= 1'b1;
    repeat (2) @(posedge ref_clk);
    sta.wr(REG_PAGE_SEL, PAGE_MAIN);
    sta.rd(REG_MODE_CTRL, rv);
    chk(rv, 16'h1040);
    w(16'h211F);
    sta.rd(REG_MODE_CTRL, rv);
    chk(rv, 16'h2100);
    // reserved code must not disturb the speed in use
    for (int c = 0; c < 4; c++) begin
      d = 16'h0100;
      d[B_SPD_LO] = c[0];
      d[B_SPD_HI] = c[1];
      w(d);
      sta.rd(REG_MODE_CTRL, rv);
      chk(rv, d);
      chk({14'h0, speed_sel}, (c == 3) ? 16'h0002 : 16'(c));
    end
    side(1'b1, 1'b0, 1'b0, MED_COPPER);
    w(16'h4100);
    drv(9'h1A5, 9'h13C);
    chk(16'(mac_rx), 16'h01A5);
    chk(16'(med_tx), 16'h0000);
    w(16'h0100);
    drv(9'h1A5, 9'h13C);
    chk(16'(mac_rx), 16'h013C);
    chk(16'(med_tx), 16'h01A5);
    w(16'h0500);
    drv(9'h1A5, 9'h13C);
    chk({mac_oe, isolate_en, 5'h0, mac_rx}, 16'h4000);
    chk(16'(med_tx), 16'h0000);
    w(16'h0580);
    drv(9'h1A5, 9'h000);
    chk1(mac_col, 1'b0);
    w(16'h0180);
    drv(9'h1A5, 9'h000);
    chk1(mac_col, 1'b1);
    w(16'h0100);
    drv(9'h1A5, 9'h000);
    chk1(mac_col, 1'b0);
    // link down so that only the unidirectional path can transmit
    for (int m = 0; m < 4; m++) begin
      side(1'b0, 1'b0, 1'b0, 3'(m));
      for (int k = 0; k < 3; k++) begin
        w((k == 0) ? 16'h0120 : (k == 1) ? 16'h1120 : 16'h0020);
        drv(9'h1A5, 9'h000);
        chk1(uni_tx_en, k == 0 && m >= 2);
        chk(16'(med_tx), (k == 0 && m >= 2) ? 16'h01A5 : 16'h0000);
      end
    end
    for (int i = 0; i < 4; i++) begin
      side(1'b1, i[0], i[1], MED_COPPER);
      w(16'h0000);
      chk1(duplex_full, i != 0);
    end
    side(1'b1, 1'b0, 1'b0, MED_COPPER);
    p0 = n_pulse;
    w(16'h1300);
    repeat (4) @(posedge ref_clk);
    chk(16'(n_pulse - p0), 16'h0001);
    sta.rd(REG_MODE_CTRL, rv);
    chk(rv, 16'h1100);
    // load non-default fields so that the restore is visible
    w(16'h6DA0);
    p0 = n_srst;
    w(16'h8000);
    chk(16'(n_srst - p0), 16'(SRST_CYC + 1));
    sta.rd(REG_MODE_CTRL, rv);
    chk(rv, 16'h1040);
    chk1(duplex_full, 1'b0);
    sta.wr(REG_PAGE_SEL, 16'h0001);
    w(16'h0100);
    sta.rd(REG_MODE_CTRL, rv);
    chk(rv, 16'h0000);
    sta.wr(REG_PAGE_SEL, PAGE_MAIN);
    sta.rd(REG_MODE_CTRL, rv);
    chk(rv, 16'h1040);
    sta.force_1000();
    #1;
    chk({14'h0, speed_sel}, 16'h0002);
    side(1'b0, 1'b0, 1'b0, MED_COPPER);
    w(16'h0940);
    drv(9'h1A5, 9'h13C);
    chk({power_down, 6'h0, mac_rx}, 16'h8000);
    w(16'h0140);
    chk1(power_down, 1'b0);
    conclude();
  end
endmodule : testbench
